// file: src/emra_top.sv
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
// Notes on behaviour
// - index clears fraction and turns only if enabled and flag was clear
// - index edge sets the seen flag
// - only software clears seen flag; clearing re-arms index reset
// - position reported as percent of turn limit, limit default 32767
// - index angle offset held, 0 to 360.0 deg, default 0.0
// - mechanical and electrical angle read-only; electrical = pairs*mech
// - alignment until first index, then angle from offset
// - start while uncalibrated raises fault, no alignment
// - alignment method 0 pull, 1 injection, default 0
// - calibration current 0.0 to 100.0 %, default 40.0
// - injection frequency 300.0 to 1000.0 Hz, default 600.0
// - 32768 fraction counts make one revolution
module emra_top
#(
    parameter int unsigned ENC_LINES = 1024
) (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [emra_pkg::AW-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // encoder
    input  wire logic                  enc_a_i,
    input  wire logic                  enc_b_i,
    input  wire logic                  enc_z_i,
    // speed feedback, units 0.001 % of absolute max speed
    input  wire logic signed [17:0]    analog_speed_i,
    output logic signed [17:0]         speed_fb_o,
    // drive control
    input  wire logic                  start_i,
    output logic                       align_active_o,
    output logic                       align_method_o,
    output logic                       uncalibrated_fault_o,
    output logic [9:0]                 calib_current_o,
    output logic [13:0]                inj_freq_o,
    output logic [11:0]                rotor_elec_angle_o
);
    import emra_pkg::*;
    localparam logic [14:0] STEP = 15'(8192 / ENC_LINES);
    if (ENC_LINES == 0 || ENC_LINES > 8192 ||
        (ENC_LINES & (ENC_LINES - 1)) != 0) begin : g_chk
        $error("ENC_LINES must be a power of two up to 8192");
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction
    function automatic logic [1:0] quad_pos(input logic [1:0] ab);
        quad_pos = {ab[1], ab[1] ^ ab[0]};
    endfunction
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    emra_ctrl_t         ctrl_q;
    emra_state_t        state_q;
    logic               seen_q, fault_q, valid_q;
    logic [14:0]        limit_q, frac_q;
    logic signed [15:0] turn_q, bias_q, pct_q;
    logic [7:0]         poles_q;
    logic [15:0]        fmax_q;
    logic [11:0]        offs_q, mech_q;
    logic [9:0]         ccur_q;
    logic [13:0]        finj_q;
    logic [1:0]         ab_q;
    logic               z_q;
    logic [31:0]        rdata;
    wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr  = acc && wb_we_i;
    wire [15:0] wv    = merge16(16'h0000, wb_dat_i, wb_sel_i);
    wire [15:0] lim_m = merge16({1'b0, limit_q}, wb_dat_i, wb_sel_i);
    wire wr_stat = wr && wb_adr_i == A_STAT && wb_sel_i[0];
    wire clr_seen  = wr_stat && !wb_dat_i[B_SEEN];
    wire clr_fault = wr_stat && !wb_dat_i[B_FAULT];
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            if (acc && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q  <= CTRL_RST;
            limit_q <= LIMIT_RST;
            bias_q  <= '0;
            poles_q <= POLES_RST;
            fmax_q  <= FMAX_RST;
            offs_q  <= '0;
            ccur_q  <= CCUR_RST;
            finj_q  <= FINJ_RST;
        end else if (wr) begin
            case (wb_adr_i)
                A_CTRL:  ctrl_q  <= wb_sel_i[0] ? emra_ctrl_t'(wb_dat_i[3:0])
                                    : ctrl_q;
                A_LIMIT: limit_q <= lim_m[14:0];
                // out-of-range values clamp to the limit
                A_BIAS:  bias_q  <= ($signed(wv) > BIAS_LIM) ? BIAS_LIM
                                    : ($signed(wv) < -BIAS_LIM) ? -BIAS_LIM
                                    : $signed(wv);
                A_POLES: poles_q <= wb_sel_i[0] ? wb_dat_i[7:0] : poles_q;
                A_FMAX: fmax_q <= merge16(fmax_q, wb_dat_i, wb_sel_i);
                A_OFFS: offs_q <= (wv[11:0] > DEG_FULL || wv[15:12] != 0)
                                  ? DEG_FULL : wv[11:0];
                A_CCUR: ccur_q <= (wv > 16'(CCUR_MAX))
                                  ? CCUR_MAX : wv[9:0];
                A_FINJ:  finj_q  <= (wv < 16'(FINJ_MIN)) ? FINJ_MIN
                                    : (wv > 16'(FINJ_MAX)) ? FINJ_MAX
                                    : wv[13:0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // encoder position
    // ------------------------------------------------------------
    wire [1:0] qd   = quad_pos({enc_a_i, enc_b_i}) - quad_pos(ab_q);
    wire step_up    = qd == 2'b01;
    wire step_dn    = qd == 2'b11;
    wire idx_ev     = enc_z_i && !z_q;
    wire [15:0] up_sum = {1'b0, frac_q} + {1'b0, STEP};
    wire [15:0] dn_sum = {1'b0, frac_q} - {1'b0, STEP};
    wire idx_clr    = idx_ev && ctrl_q.index_reset_enable && !seen_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ab_q <= 2'b00;
            z_q  <= 1'b0;
        end else begin
            ab_q <= {enc_a_i, enc_b_i};
            z_q  <= enc_z_i;
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frac_q <= '0;
            turn_q <= '0;
        end else if (idx_clr) begin
            frac_q <= '0;
            turn_q <= '0;
        end else if (step_up) begin
            frac_q <= up_sum[14:0];
            if (up_sum[15] && turn_q != TURN_MAX) begin
                turn_q <= turn_q + 16'sd1;
            end
        end else if (step_dn) begin
            frac_q <= dn_sum[14:0];
            if (dn_sum[15] && turn_q != TURN_MIN) begin
                turn_q <= turn_q - 16'sd1;
            end
        end
    end
    // set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen_q <= 1'b0;
        end else if (idx_ev) begin
            seen_q <= 1'b1;
        end else if (clr_seen) begin
            seen_q <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // alignment sequencing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_q <= 1'b0;
            state_q <= EMRA_IDLE;
        end else begin
            if (idx_ev) begin
                valid_q <= 1'b1;
            end
            case (state_q)
                EMRA_IDLE: begin
                    if (start_i && ctrl_q.calibrated) begin
                        state_q <= (valid_q || idx_ev)
                                   ? EMRA_RUN : EMRA_ALIGN;
                    end
                end
                EMRA_ALIGN: begin
                    if (idx_ev) begin
                        state_q <= EMRA_RUN;
                    end
                end
                EMRA_RUN: ;
                default: state_q <= EMRA_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_q <= 1'b0;
        end else if (start_i && !ctrl_q.calibrated) begin
            fault_q <= 1'b1;
        end else if (clr_fault) begin
            fault_q <= 1'b0;
        end
    end
    assign align_active_o       = state_q == EMRA_ALIGN;
    assign align_method_o       = ctrl_q.align_method;
    assign uncalibrated_fault_o = fault_q;
    assign calib_current_o      = ccur_q;
    assign inj_freq_o           = finj_q;
    // ------------------------------------------------------------
    // angles, 0.1 deg units
    // ------------------------------------------------------------
    wire [26:0] mech_p = 27'(frac_q) * 27'(DEG_FULL);
    wire [22:0] ef_p   = 23'(frac_q) * 23'(poles_q[7:1]);
    wire [26:0] elec_p = 27'(ef_p[14:0]) * 27'(DEG_FULL);
    // before the first index the offset means nothing, so it is left out
    wire [12:0] elec_s = {1'b0, elec_p[26:15]} +
                         (valid_q ? {1'b0, offs_q} : 13'h0000);
    wire [12:0] elec_w = (elec_s >= {1'b0, DEG_FULL})
                         ? elec_s - {1'b0, DEG_FULL} : elec_s;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mech_q             <= '0;
            rotor_elec_angle_o <= '0;
        end else begin
            mech_q             <= mech_p[26:15];
            rotor_elec_angle_o <= elec_w[11:0];
        end
    end
    // ------------------------------------------------------------
    // percent of turn limit and speed feedback
    // ------------------------------------------------------------
    wire signed [30:0] pos   = {turn_q, frac_q};
    wire signed [45:0] num   = 46'(pos) * $signed({32'h0, PCT_SCALE});
    wire signed [31:0] den   = $signed({2'b00, limit_q, 15'h0000});
    wire signed [45:0] quo   = (limit_q == '0) ? '0 : num / 46'(den);
    wire signed [18:0] sum   = 19'(analog_speed_i) + 19'(bias_q);
    wire signed [17:0] sum_s = (sum > 19'sh1ffff) ? 18'sh1ffff :
                               (sum < -19'sh20000) ? -18'sh20000 :
                               sum[17:0];
    wire [23:0] rpm_n = fmax_q * RPM_NUM;
    wire [15:0] rpm   = (poles_q == '0) ? '0
                        : 16'(rpm_n / {15'h0000, poles_q, 1'b0});
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pct_q      <= '0;
            speed_fb_o <= '0;
        end else begin
            pct_q <= (quo > 46'(PCT_LIM)) ? PCT_LIM :
                     (quo < -46'(PCT_LIM)) ? -PCT_LIM : quo[15:0];
            speed_fb_o <= ctrl_q.feedback_source_select
                          ? sum_s : analog_speed_i;
        end
    end
    // ------------------------------------------------------------
    // read decode; unmapped reads return zero
    // ------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            A_CTRL:  rdata[3:0]  = ctrl_q;
            A_STAT:  rdata[3:0]  = {align_active_o, valid_q,
                                    fault_q, seen_q};
            A_TURN:  rdata       = 32'(turn_q);
            A_FRAC:  rdata[14:0] = frac_q;
            A_LIMIT: rdata[14:0] = limit_q;
            A_PCT:   rdata       = 32'(pct_q);
            A_BIAS:  rdata       = 32'(bias_q);
            A_POLES: rdata[7:0]  = poles_q;
            A_FMAX:  rdata[15:0] = fmax_q;
            A_RPM:   rdata[15:0] = rpm;
            A_OFFS:  rdata[11:0] = offs_q;
            A_MECH:  rdata[11:0] = mech_q;
            A_ELEC:  rdata[11:0] = rotor_elec_angle_o;
            A_CCUR:  rdata[9:0]  = ccur_q;
            A_FINJ:  rdata[13:0] = finj_q;
            default: rdata       = 32'h0000_0000;
        endcase
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_idx_clr;
        idx_ev && ctrl_q.index_reset_enable && !seen_q
        |=> frac_q == '0 && turn_q == '0;
    endproperty
    a_idx_clr: assert property (p_idx_clr)
        else $error("index did not clear position");
    property p_idx_keep;
        idx_ev && seen_q && !step_up && !step_dn
        |=> frac_q == $past(frac_q) && turn_q == $past(turn_q);
    endproperty
    a_idx_keep: assert property (p_idx_keep)
        else $error("index cleared position while flag set");
    property p_seen_set;
        idx_ev |=> seen_q;
    endproperty
    a_seen_set: assert property (p_seen_set)
        else $error("seen flag not set by index");
    property p_seen_hold;
        seen_q && !clr_seen |=> seen_q;
    endproperty
    a_seen_hold: assert property (p_seen_hold)
        else $error("seen flag dropped without software");
    property p_bias;
        ctrl_q.feedback_source_select |=> speed_fb_o == $past(sum_s)
            && bias_q <= BIAS_LIM && bias_q >= -BIAS_LIM;
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias not applied");
    property p_pct;
        limit_q == '0 ##1 limit_q == '0 |=> pct_q == '0;
    endproperty
    a_pct: assert property (p_pct)
        else $error("percent not zero for zero limit");
    property p_angle;
        mech_q < DEG_FULL && rotor_elec_angle_o < DEG_FULL
        && offs_q <= DEG_FULL;
    endproperty
    a_angle: assert property (p_angle)
        else $error("angle out of range");
    property p_align;
        start_i && ctrl_q.calibrated && !valid_q && !idx_ev
        && state_q == EMRA_IDLE |=> align_active_o;
    endproperty
    a_align: assert property (p_align)
        else $error("alignment not started");
    property p_align_end;
        align_active_o && idx_ev |=> !align_active_o ##1 !align_active_o;
    endproperty
    a_align_end: assert property (p_align_end)
        else $error("alignment kept after index");
    property p_fault;
        start_i && !ctrl_q.calibrated && !align_active_o
        |=> fault_q && !align_active_o;
    endproperty
    a_fault: assert property (p_fault)
        else $error("uncalibrated start not faulted");
    property p_ranges;
        ccur_q <= CCUR_MAX && finj_q >= FINJ_MIN && finj_q <= FINJ_MAX;
    endproperty
    a_ranges: assert property (p_ranges)
        else $error("setting out of range");
    property p_wrap;
        step_up && !idx_clr && up_sum[15] && turn_q != TURN_MAX
        |=> turn_q == $past(turn_q) + 16'sd1
            && frac_q == $past(up_sum[14:0]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("turn count not stepped on wrap");
endmodule

// file: src/emra_pkg.sv
package emra_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          AW         = 8;
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_STAT     = 8'h04;
    localparam logic [7:0]  A_TURN     = 8'h08;
    localparam logic [7:0]  A_FRAC     = 8'h0c;
    localparam logic [7:0]  A_LIMIT    = 8'h10;
    localparam logic [7:0]  A_PCT      = 8'h14;
    localparam logic [7:0]  A_BIAS     = 8'h18;
    localparam logic [7:0]  A_POLES    = 8'h1c;
    localparam logic [7:0]  A_FMAX     = 8'h20;
    localparam logic [7:0]  A_RPM      = 8'h24;
    localparam logic [7:0]  A_OFFS     = 8'h28;
    localparam logic [7:0]  A_MECH     = 8'h2c;
    localparam logic [7:0]  A_ELEC     = 8'h30;
    localparam logic [7:0]  A_CCUR     = 8'h34;
    localparam logic [7:0]  A_FINJ     = 8'h38;
    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    localparam int          B_SEEN     = 0;
    localparam int          B_FAULT    = 1;
    localparam int          B_VALID    = 2;
    localparam int          B_ALIGN    = 3;
    // ------------------------------------------------------------
    // limits and reset values
    // ------------------------------------------------------------
    localparam logic [14:0] LIMIT_RST  = 15'h7fff;
    localparam logic signed [15:0] TURN_MAX = 16'sh7fff;
    localparam logic signed [15:0] TURN_MIN = -16'sh7fff;
    localparam logic signed [15:0] BIAS_LIM = 16'sh2710; // 10.000 %
    localparam logic signed [15:0] PCT_LIM  = 16'sh2710; // 100.00 %
    localparam logic [13:0] PCT_SCALE  = 14'h2710;
    localparam logic [11:0] DEG_FULL   = 12'he10;        // 360.0 deg
    localparam logic [9:0]  CCUR_MAX   = 10'h3e8;        // 100.0 %
    localparam logic [9:0]  CCUR_RST   = 10'h190;        // 40.0 %
    localparam logic [13:0] FINJ_MIN   = 14'h0bb8;       // 300.0 Hz
    localparam logic [13:0] FINJ_MAX   = 14'h2710;       // 1000.0 Hz
    localparam logic [13:0] FINJ_RST   = 14'h1770;       // 600.0 Hz
    localparam logic [7:0]  POLES_RST  = 8'h04;
    localparam logic [15:0] FMAX_RST   = 16'h0258;       // 60.0 Hz
    localparam logic [7:0]  RPM_NUM    = 8'h1b;          // 120*1.125/10/... 
    localparam int          REV_COUNTS = 32768;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic calibrated;
        logic align_method;
        logic feedback_source_select;
        logic index_reset_enable;
    } emra_ctrl_t;

    localparam emra_ctrl_t CTRL_RST = '0;

    typedef enum logic [1:0] {
        EMRA_IDLE  = 2'b00,
        EMRA_ALIGN = 2'b01,
        EMRA_RUN   = 2'b11
    } emra_state_t;
endpackage

// file: tb/emra_enc_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// quadrature encoder with index channel
// ------------------------------------------------------------
module emra_enc_model (
    // clock
    input  wire logic       clk_i,
    // bench commands: 01 up, 10 down
    input  wire logic [1:0] move_i,
    input  wire logic       index_i,
    // encoder lines
    output logic            enc_a_o,
    output logic            enc_b_o,
    output logic            enc_z_o
);
    logic [1:0] ph_q = 2'h0;
    logic       z_q  = 1'b0;
    // one quadrature edge per cycle at most; up steps ab 00,01,11,10
    always @(posedge clk_i) begin
        if (move_i == 2'h1) ph_q <= ph_q + 2'h1;
        else if (move_i == 2'h2) ph_q <= ph_q - 2'h1;
        z_q <= index_i;
    end
    assign enc_a_o = ph_q[1];
    assign enc_b_o = ph_q[0] ^ ph_q[1];
    assign enc_z_o = z_q;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import emra_pkg::*;
    localparam int STEP = 8192 / 1024;
    logic clk = 1'b0, rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, z = 1'b0, start = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [1:0]  mv = 2'h0;
    logic        ack, ea, eb, ez, aln, amth, flt;
    logic [9:0]  ccur;
    logic [13:0] finj;
    logic [11:0] elec;
    logic signed [17:0] ana = '0, sfb;
    logic [31:0] exp_q[$];
    int fails = 0, check_count = 0, cyc_n = 0, seed = 32'h2aa3, r;
    initial forever #2.5 clk = ~clk;
    emra_enc_model ENC (.clk_i(clk), .move_i(mv), .index_i(z),
        .enc_a_o(ea), .enc_b_o(eb), .enc_z_o(ez));
    emra_top #(.ENC_LINES(1024)) DUT (.sys_clk_i(clk), .resetn_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .enc_a_i(ea), .enc_b_i(eb), .enc_z_i(ez), .analog_speed_i(ana),
        .speed_fb_o(sfb), .start_i(start), .align_active_o(aln),
        .align_method_o(amth), .uncalibrated_fault_o(flt),
        .calib_current_o(ccur), .inj_freq_o(finj),
        .rotor_elec_angle_o(elec));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ------------------------------------------------------------
    // scoreboard: oldest expected read value against each read ack
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk("unexpected read", 32'h0, rdat);
            else chk("read data", exp_q.pop_front(), rdat);
        end
    end
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask
    task automatic steps(input int n, input logic [1:0] dir);
        repeat (n) @(posedge clk) mv <= dir;
        @(posedge clk) mv <= 2'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic pulse_index();
        @(posedge clk) z <= 1'b1;
        @(posedge clk) z <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic kick();
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic stop_test();
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // long wrap walk is ~4.1k cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_LIMIT, 32'h7fff);
        rd(A_OFFS, 32'h0);
        rd(A_CCUR, 32'd400);
        rd(A_FINJ, 32'd6000);
        rd(A_CTRL, 32'h0);
        rd(8'h3c, 32'h0);
        // start while uncalibrated must fault and not align
        kick();
        chk("fault", 1'b1, flt);
        chk("align", 1'b0, aln);
        rd(A_STAT, 32'h2);
        wb(A_STAT, 1'b1, 32'h0);
        rd(A_STAT, 32'h0);
        wb(A_CTRL, 1'b1, 32'h9);
        @(posedge clk);
        chk("method pull", 1'b0, amth);
        wb(A_CTRL, 1'b1, 32'hf);
        @(posedge clk);
        chk("method inj", 1'b1, amth);
        kick();
        chk("align on", 1'b1, aln);
        rd(A_STAT, 32'h8);
        // one full revolution plus four edges, then back over the wrap
        steps(4096 + 4, 2'h1);
        rd(A_FRAC, 32'(4 * STEP));
        rd(A_TURN, 32'h1);
        steps(5, 2'h2);
        rd(A_FRAC, 32'(32768 - STEP));
        rd(A_TURN, 32'h0);
        pulse_index();
        rd(A_FRAC, 32'h0);
        rd(A_STAT, 32'h5);
        chk("align off", 1'b0, aln);
        steps(3, 2'h1);
        pulse_index();
        rd(A_FRAC, 32'(3 * STEP));
        rd(A_STAT, 32'h5);
        wb(A_STAT, 1'b1, 32'h0);
        rd(A_STAT, 32'h4);
        pulse_index();
        rd(A_FRAC, 32'h0);
        // a quarter turn: 900 mech, two pole pairs give 1800 elec
        steps(1024, 2'h1);
        rd(A_MECH, 32'd900);
        rd(A_ELEC, 32'd1800);
        chk("elec angle", 32'd1800, 32'(elec));
        // bias clamp and sum with random feedback
        wb(A_BIAS, 1'b1, 32'd20000);
        rd(A_BIAS, 32'd10000);
        repeat (4) begin
            r = $random(seed) % 50000;
            @(posedge clk) ana <= 18'(r);
            repeat (3) @(posedge clk);
            chk("speed fb", 32'(18'(r + 10000)), 32'(sfb));
        end
        wb(A_CTRL, 1'b1, 32'h9);
        repeat (3) @(posedge clk);
        chk("speed raw", 32'(ana), 32'(sfb));
        wb(A_CCUR, 1'b1, 32'd2000);
        rd(A_CCUR, 32'd1000);
        chk("calib cur", 32'd1000, 32'(ccur));
        wb(A_FINJ, 1'b1, 32'd100);
        rd(A_FINJ, 32'd3000);
        chk("inj freq", 32'd3000, 32'(finj));
        wb(A_OFFS, 1'b1, 32'd5000);
        rd(A_OFFS, 32'd3600);
        wb(A_LIMIT, 1'b1, 32'h1);
        rd(A_PCT, 32'd2500);
        wb(A_LIMIT, 1'b1, 32'h0);
        rd(A_PCT, 32'h0);
        repeat (4) @(posedge clk);
        chk("queue empty", 32'h0, 32'(exp_q.size()));
        stop_test();
    end
endmodule
